// file: hdl/engine_fault_supervisor_defines.vh
`ifndef ENGINE_FAULT_SUPERVISOR_DEFINES_VH
`define ENGINE_FAULT_SUPERVISOR_DEFINES_VH

// ----------------------------------------
// clock and time base
// ----------------------------------------
`define CLK_FREQ_HZ        125000000
`define TICK_PERIOD_US     1000
`define TICK_CYCLES        ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)

// ----------------------------------------
// supervision defaults, in ticks of 1 ms
// ----------------------------------------
`define MOTOR_SPINUP_MS    16'h07D0
`define MOTOR_OFFSPEED_MS  16'h01F4
`define FAN_LOCK_MS        16'h0BB8
`define SLEEVE_RISE_MS     16'h3A98
`define ZC_WINDOW_MS       16'h03E8

// ----------------------------------------
// limits, in raw sensor units
// ----------------------------------------
`define TEMP_LOW_LIMIT     12'h040
`define TEMP_HIGH_LIMIT    12'hF00
`define SLEEVE_RISE_LEVEL  12'h300
`define CURRENT_LIMIT      12'hC00
`define SPEED_LOW          16'h0F00
`define SPEED_HIGH         16'h1100
`define ZC_MIN_EDGES       16'h005A
`define ZC_MAX_EDGES       16'h0082

// ----------------------------------------
// controller states
// ----------------------------------------
`define HST_IDLE           2'h0
`define HST_HEAT           2'h1
`define HST_CUT            2'h2
`define HST_FAIL           2'h3

`endif

// file: hdl/motor_monitor.v
`timescale 1ns/10ps
`include "engine_fault_supervisor_defines.vh"
`default_nettype none

module motor_monitor #(
   parameter [15:0] SPINUP_TICKS   = `MOTOR_SPINUP_MS,
   parameter [15:0] OFFSPEED_TICKS = `MOTOR_OFFSPEED_MS,
   parameter [15:0] SPEED_LO       = `SPEED_LOW,
   parameter [15:0] SPEED_HI       = `SPEED_HIGH
) (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   input  wire        tick,
   // motor
   input  wire        run,
   input  wire [15:0] speed,
   // result
   output reg         fail_q
);

   reg        spun_q;
   reg [15:0] cnt_q;
   wire       in_range = (speed >= SPEED_LO) && (speed <= SPEED_HI);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         spun_q <= 1'b0;
         cnt_q  <= 16'h0000;
         fail_q <= 1'b0;
      end else if (!run) begin
         spun_q <= 1'b0;
         cnt_q  <= 16'h0000;
      end else if (!spun_q) begin
         if (in_range) begin
            spun_q <= 1'b1;
            cnt_q  <= 16'h0000;
         end else if (tick) begin
            if (cnt_q >= SPINUP_TICKS)
               fail_q <= 1'b1;
            else
               cnt_q <= cnt_q + 16'h0001;
         end
      end else if (in_range) begin
         cnt_q <= 16'h0000;
      end else if (tick) begin
         if (cnt_q >= OFFSPEED_TICKS)
            fail_q <= 1'b1;
         else
            cnt_q <= cnt_q + 16'h0001;
      end
   end

endmodule

`default_nettype wire

// file: hdl/engine_fault_supervisor.v
// Notes on behaviour
// - motor fails if not up to speed in time
// - motor fails if off speed too long
// - supervise only belt, drum, developing, fuser motors
// - fan fails if locked too long while run
// - supply fan full/half, fuser fan full only
// - heater drives follow main and sleeve temps
// - abnormal temperature removes heater drives
// - overcurrent drops drives and relay
// - cut power first, then report fuser fault
// - sleeve must reach level within heat time
// - low temperature while heating is a fault once sleeve has risen
// - high temperature always a fault
// - zero-cross frequency checked at power-on, standby
`timescale 1ns/10ps
`include "engine_fault_supervisor_defines.vh"
`default_nettype none

module engine_fault_supervisor #(
   parameter [15:0] SPINUP_TICKS   = `MOTOR_SPINUP_MS,
   parameter [15:0] OFFSPEED_TICKS = `MOTOR_OFFSPEED_MS,
   parameter [15:0] SPEED_LO       = `SPEED_LOW,
   parameter [15:0] SPEED_HI       = `SPEED_HIGH,
   parameter [15:0] FAN_TICKS      = `FAN_LOCK_MS,
   parameter [15:0] RISE_TICKS     = `SLEEVE_RISE_MS,
   parameter [15:0] ZC_TICKS       = `ZC_WINDOW_MS,
   parameter [15:0] ZC_MIN         = `ZC_MIN_EDGES,
   parameter [15:0] ZC_MAX         = `ZC_MAX_EDGES,
   parameter [11:0] TEMP_LO        = `TEMP_LOW_LIMIT,
   parameter [11:0] TEMP_HI        = `TEMP_HIGH_LIMIT,
   parameter [11:0] RISE_LEVEL     = `SLEEVE_RISE_LEVEL,
   parameter [11:0] CUR_LIMIT      = `CURRENT_LIMIT,
   parameter [31:0] TICK_CYCLES    = `TICK_CYCLES
) (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // supervised motors: belt, drum, developing, fuser
   input  wire [3:0]  motor_run,
   input  wire [63:0] motor_speed,
   // fans
   input  wire        supply_fan_run,
   input  wire        supply_fan_half,
   input  wire        fuser_fan_run,
   input  wire        supply_fan_lock,
   input  wire        fuser_fan_lock,
   output reg         supply_cooling_fan,
   output reg         supply_fan_half_speed,
   output reg         fuser_cooling_fan,
   // fuser
   input  wire        heat_request,
   input  wire        printing,
   input  wire        standby,
   input  wire [11:0] target_temp,
   input  wire [11:0] sleeve_temp_sensor,
   input  wire [11:0] main_heater_temp_sensor,
   input  wire [11:0] front_end_temp_sensor,
   input  wire [11:0] rear_end_temp_sensor,
   input  wire [11:0] heater_current_sense,
   input  wire        zero_cross,
   output reg         main_heater_drive,
   output reg         sub_heater_drive,
   output reg         heater_relay,
   // failure reports
   output wire [3:0]  motor_fail,
   output reg  [1:0]  fan_fail,
   output reg         fuser_fail,
   output reg         zero_cross_fail
);

   // ----------------------------------------
   // time base
   // ----------------------------------------
   reg [31:0] div_q;
   wire       tick = (div_q == TICK_CYCLES - 32'd1);

   always @(posedge clk or posedge rst) begin
      if (rst)
         div_q <= 32'd0;
      else if (tick)
         div_q <= 32'd0;
      else
         div_q <= div_q + 32'd1;
   end

   // ----------------------------------------
   // motors
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : mon
         motor_monitor #(
            .SPINUP_TICKS   (SPINUP_TICKS),
            .OFFSPEED_TICKS (OFFSPEED_TICKS),
            .SPEED_LO       (SPEED_LO),
            .SPEED_HI       (SPEED_HI)
         ) u_mon (
            .clk    (clk),
            .rst    (rst),
            .tick   (tick),
            .run    (motor_run[g]),
            .speed  (motor_speed[16*g+15:16*g]),
            .fail_q (motor_fail[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // fans
   // ----------------------------------------
   reg [15:0] fan0_q;
   reg [15:0] fan1_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         supply_cooling_fan    <= 1'b0;
         supply_fan_half_speed <= 1'b0;
         fuser_cooling_fan     <= 1'b0;
         fan0_q                <= 16'h0000;
         fan1_q                <= 16'h0000;
         fan_fail              <= 2'b00;
      end else begin
         supply_cooling_fan    <= supply_fan_run;
         supply_fan_half_speed <= supply_fan_run & supply_fan_half;
         fuser_cooling_fan     <= fuser_fan_run;
         if (!supply_fan_run || !supply_fan_lock)
            fan0_q <= 16'h0000;
         else if (tick) begin
            if (fan0_q >= FAN_TICKS)
               fan_fail[0] <= 1'b1;
            else
               fan0_q <= fan0_q + 16'h0001;
         end
         if (!fuser_fan_run || !fuser_fan_lock)
            fan1_q <= 16'h0000;
         else if (tick) begin
            if (fan1_q >= FAN_TICKS)
               fan_fail[1] <= 1'b1;
            else
               fan1_q <= fan1_q + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // fuser fault conditions
   // ----------------------------------------
   wire any_high = (sleeve_temp_sensor >= TEMP_HI) || (main_heater_temp_sensor >= TEMP_HI) ||
                   (front_end_temp_sensor >= TEMP_HI) || (rear_end_temp_sensor >= TEMP_HI);
   wire any_low  = (sleeve_temp_sensor <= TEMP_LO) || (main_heater_temp_sensor <= TEMP_LO) ||
                   (front_end_temp_sensor <= TEMP_LO) || (rear_end_temp_sensor <= TEMP_LO);
   wire over_cur = (heater_current_sense >= CUR_LIMIT);
   reg  [1:0]  hst_q;
   reg  [15:0] rise_q;
   reg         risen_q;
   wire        heating  = (hst_q == `HST_HEAT);
   wire        rise_to  = heating && !risen_q && tick && (rise_q >= RISE_TICKS);
   wire        low_flt  = heating && risen_q && (printing || heat_request) && any_low;
   wire        fault    = any_high || over_cur || rise_to || low_flt;

   // ----------------------------------------
   // heater controller
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hst_q             <= `HST_IDLE;
         rise_q            <= 16'h0000;
         risen_q           <= 1'b0;
         main_heater_drive <= 1'b0;
         sub_heater_drive  <= 1'b0;
         heater_relay      <= 1'b0;
         fuser_fail        <= 1'b0;
      end else begin
         case (hst_q)
            `HST_IDLE: begin
               main_heater_drive <= 1'b0;
               sub_heater_drive  <= 1'b0;
               rise_q            <= 16'h0000;
               risen_q           <= 1'b0;
               if (fault) begin
                  heater_relay <= 1'b0;
                  hst_q        <= `HST_CUT;
               end else if (heat_request) begin
                  heater_relay <= 1'b1;
                  hst_q        <= `HST_HEAT;
               end else
                  heater_relay <= 1'b0;
            end
            `HST_HEAT: begin
               if (fault) begin
                  main_heater_drive <= 1'b0;
                  sub_heater_drive  <= 1'b0;
                  heater_relay      <= 1'b0;
                  hst_q             <= `HST_CUT;
               end else if (!heat_request) begin
                  main_heater_drive <= 1'b0;
                  sub_heater_drive  <= 1'b0;
                  hst_q             <= `HST_IDLE;
               end else begin
                  main_heater_drive <= (main_heater_temp_sensor < target_temp);
                  sub_heater_drive  <= (sleeve_temp_sensor < target_temp);
                  if (sleeve_temp_sensor >= RISE_LEVEL)
                     risen_q <= 1'b1;
                  else if (tick && !risen_q)
                     rise_q <= rise_q + 16'h0001;
               end
            end
            `HST_CUT: begin
               main_heater_drive <= 1'b0;
               sub_heater_drive  <= 1'b0;
               heater_relay      <= 1'b0;
               hst_q             <= `HST_FAIL;
            end
            `HST_FAIL: begin
               main_heater_drive <= 1'b0;
               sub_heater_drive  <= 1'b0;
               heater_relay      <= 1'b0;
               fuser_fail        <= 1'b1;
            end
            default: hst_q <= `HST_CUT;
         endcase
      end
   end

   // ----------------------------------------
   // zero-cross frequency check
   // ----------------------------------------
   reg        zc_prev_q;
   reg        zc_done_q;
   reg [15:0] zc_win_q;
   reg [15:0] zc_cnt_q;
   wire       zc_check = standby || !zc_done_q;
   wire       zc_rise  = zero_cross && !zc_prev_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         zc_prev_q       <= 1'b0;
         zc_done_q       <= 1'b0;
         zc_win_q        <= 16'h0000;
         zc_cnt_q        <= 16'h0000;
         zero_cross_fail <= 1'b0;
      end else begin
         zc_prev_q <= zero_cross;
         if (!zc_check) begin
            zc_win_q <= 16'h0000;
            zc_cnt_q <= 16'h0000;
         end else if (tick && zc_win_q >= ZC_TICKS - 16'h0001) begin
            if (zc_cnt_q < ZC_MIN || zc_cnt_q > ZC_MAX)
               zero_cross_fail <= 1'b1;
            zc_done_q <= 1'b1;
            zc_win_q  <= 16'h0000;
            zc_cnt_q  <= 16'h0000;
         end else begin
            if (tick)
               zc_win_q <= zc_win_q + 16'h0001;
            if (zc_rise)
               zc_cnt_q <= zc_cnt_q + 16'h0001;
         end
      end
   end

endmodule

`default_nettype wire

// file: tb/efs_checker_props.sv
`timescale 1ns/10ps
`default_nettype none
module efs_checker #(
   parameter [11:0] TEMP_HI   = 12'hF00,
   parameter [11:0] CUR_LIMIT = 12'hC00
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // fans
   input wire logic        supply_fan_run,
   input wire logic        supply_fan_half,
   input wire logic        fuser_fan_run,
   input wire logic        supply_cooling_fan,
   input wire logic        supply_fan_half_speed,
   input wire logic        fuser_cooling_fan,
   // fuser
   input wire logic [11:0] target_temp,
   input wire logic [11:0] sleeve_temp_sensor,
   input wire logic [11:0] main_heater_temp_sensor,
   input wire logic [11:0] front_end_temp_sensor,
   input wire logic [11:0] rear_end_temp_sensor,
   input wire logic [11:0] heater_current_sense,
   input wire logic        main_heater_drive,
   input wire logic        sub_heater_drive,
   input wire logic        heater_relay,
   input wire logic        fuser_fail
);
   // ----
   // helpers
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire hot = (sleeve_temp_sensor >= TEMP_HI) | (main_heater_temp_sensor >= TEMP_HI) |
              (front_end_temp_sensor >= TEMP_HI) | (rear_end_temp_sensor >= TEMP_HI);
   sequence power_cut;
      !main_heater_drive && !sub_heater_drive && !heater_relay;
   endsequence
   // ----
   // properties
   // ----
   a_supply_fan_on: assert property (supply_fan_run |=> supply_cooling_fan)
      else $error("supply fan not driven");
   a_supply_fan_half: assert property (supply_fan_run && supply_fan_half |=> supply_fan_half_speed)
      else $error("supply fan half speed missing");
   a_fuser_fan_follow: assert property (fuser_fan_run |=> fuser_cooling_fan)
      else $error("fuser fan not driven");
   a_overcurrent_cut: assert property (heater_current_sense >= CUR_LIMIT |=> power_cut)
      else $error("heater power kept on overcurrent");
   a_high_temp_fail: assert property (hot |-> ##3 fuser_fail)
      else $error("high temperature not reported");
   a_cut_before_report: assert property ($rose(fuser_fail) |->
      !$past(heater_relay, 2) && !$past(main_heater_drive, 2) && !$past(sub_heater_drive, 2))
      else $error("fault reported before power cut");
   a_fail_holds_cut: assert property (fuser_fail |-> power_cut ##1 fuser_fail)
      else $error("heater live or fault cleared after failure");
   a_main_drive_off: assert property (main_heater_temp_sensor >= target_temp |=> !main_heater_drive)
      else $error("main heater driven above target");
   a_sub_drive_off: assert property (sleeve_temp_sensor >= target_temp |=> !sub_heater_drive)
      else $error("sub heater driven above target");
endmodule
bind engine_fault_supervisor efs_checker #(.TEMP_HI(TEMP_HI), .CUR_LIMIT(CUR_LIMIT)) u_chk (.*);
`default_nettype wire

// file: tb/formatter_model.sv
`timescale 1ns/10ps
`default_nettype none
module formatter_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // heater state and report
   input wire logic main_heater_drive,
   input wire logic sub_heater_drive,
   input wire logic heater_relay,
   input wire logic fuser_fail,
   output var logic order_bad
);
   // ----
   // flags a report that arrives while heater power is still live
   // ----
   logic seen_q;
   logic pwr_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         seen_q    <= 1'b0;
         pwr_q     <= 1'b0;
         order_bad <= 1'b0;
      end else begin
         seen_q <= fuser_fail;
         pwr_q  <= main_heater_drive | sub_heater_drive | heater_relay;
         if (fuser_fail && !seen_q && pwr_q) order_bad <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: tb/engine_fault_supervisor_bench.sv
`timescale 1ns/10ps
`default_nettype none
module engine_fault_supervisor_bench;
   logic clk = 0, rst = 1, zero_cross = 0, zc_en = 1;
   logic [3:0] motor_run = 0;
   logic [63:0] motor_speed = 0;
   logic supply_fan_run = 0, supply_fan_half = 0, fuser_fan_run = 0;
   logic supply_fan_lock = 0, fuser_fan_lock = 0, heat_request = 0, printing = 0, standby = 0;
   logic [11:0] target_temp = 12'h200, sleeve_temp_sensor = 12'h100;
   logic [11:0] main_heater_temp_sensor = 12'h100, front_end_temp_sensor = 12'h100;
   logic [11:0] rear_end_temp_sensor = 12'h100, heater_current_sense = 0;
   wire supply_cooling_fan, supply_fan_half_speed, fuser_cooling_fan, main_heater_drive;
   wire sub_heater_drive, heater_relay, fuser_fail, zero_cross_fail, order_bad;
   wire [3:0] motor_fail;
   wire [1:0] fan_fail;
   logic [5:0] zc_cnt = 0;
   int n_mismatch = 0, checks_done = 0, ncyc = 0;
   // zero-cross window and limits left at their defaults: 1000 ticks, 90..130 rises
   engine_fault_supervisor #(.TICK_CYCLES(32'h0000000A), .SPINUP_TICKS(16'h0004),
      .OFFSPEED_TICKS(16'h0003), .FAN_TICKS(16'h0003), .RISE_TICKS(16'h0006)) DUT (.*);
   formatter_model u_fmt (.*);
   // ----
   // clock, mains crossing, timeout
   // ----
   always #4 clk = ~clk;
   always @(posedge clk) begin
      // one rise every 100 cycles: about 100 rises per 10000-cycle window
      zc_cnt <= (zc_cnt == 6'h31) ? 6'h00 : zc_cnt + 6'h01;
      if (zc_en && zc_cnt == 6'h31) zero_cross <= #1 ~zero_cross;
      ncyc++;
      if (ncyc == 25000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   // ----
   // tasks
   // ----
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task setup(input logic h, input logic [11:0] m, input logic [11:0] s);
      rst = 1;
      cyc(2);
      rst = 0;
      heat_request = h;
      printing = h;
      main_heater_temp_sensor = m;
      sleeve_temp_sensor = s;
      cyc(1);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ----
   // tests
   // ----
   initial begin
      setup(0, 12'h100, 12'h100);
      chk({motor_fail, main_heater_drive, heater_relay, fuser_fail}, 0);
      supply_fan_run = 1;
      supply_fan_half = 1;
      fuser_fan_run = 1;
      cyc(1);
      chk({supply_cooling_fan, supply_fan_half_speed, fuser_cooling_fan}, 3'h7);
      supply_fan_half = 0;
      fuser_fan_run = 0;
      supply_fan_lock = 1;
      fuser_fan_lock = 1;
      cyc(1);
      chk({supply_fan_half_speed, fuser_cooling_fan}, 0);
      cyc(80);
      chk(fan_fail, 2'h1);
      fuser_fan_run = 1;
      cyc(60);
      chk(fan_fail, 2'h3);
      $display("test done: fans");
      motor_speed = {16'h0000, 16'h1000, 16'h0000, 16'h1000};
      motor_run = 4'h7;
      cyc(30);
      chk(motor_fail, 0);
      motor_speed[47:32] = 16'h0000;
      cyc(100);
      chk(motor_fail, 4'h6);
      chk(zero_cross_fail, 0);
      $display("test done: motors");
      setup(1, 12'h100, 12'h400);
      cyc(2);
      chk({main_heater_drive, sub_heater_drive, heater_relay}, 3'h5);
      main_heater_temp_sensor = 12'h300;
      sleeve_temp_sensor = 12'h100;
      cyc(2);
      chk({main_heater_drive, sub_heater_drive, heater_relay}, 3'h3);
      heater_current_sense = 12'hC00;
      cyc(2);
      chk({main_heater_drive, sub_heater_drive, heater_relay, fuser_fail}, 0);
      heater_current_sense = 0;
      cyc(8);
      chk({heater_relay, fuser_fail}, 2'h1);
      $display("test done: overcurrent");
      setup(0, 12'h100, 12'h100);
      front_end_temp_sensor = 12'hF00;
      cyc(6);
      chk({heater_relay, fuser_fail}, 2'h1);
      front_end_temp_sensor = 12'h100;
      setup(1, 12'h100, 12'h100);
      cyc(20);
      chk({heater_relay, fuser_fail}, 2'h2);
      cyc(100);
      chk({heater_relay, fuser_fail}, 2'h1);
      setup(1, 12'h100, 12'h400);
      cyc(5);
      sleeve_temp_sensor = 12'h040;
      cyc(8);
      chk({heater_relay, fuser_fail}, 2'h1);
      $display("test done: fuser faults");
      setup(0, 12'h100, 12'h100);
      standby = 1;
      cyc(10100);
      chk(zero_cross_fail, 0);
      zc_en = 0;
      cyc(10100);
      chk(zero_cross_fail, 1);
      chk(order_bad, 0);
      $display("test done: zero cross");
      wrap_up;
   end
endmodule
`default_nettype wire
